// ---- rtl/sar_accel_ramp.sv ----
module sar_accel_ramp #(
  parameter int TICK_CYCLES = sar_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Motor side status
  input wire logic rampSelPin,
  input wire logic fullSpeed,
  input wire logic overloadTrip,
  input wire logic motorCurrentSeen,
  // Set-point and indications
  output logic [15:0] setPoint,
  output logic [1:0] setPointKind,
  output logic up_to_speed,
  output logic [7:0] faultCode,
  output logic irq
);
  import sar_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [CTRL_W-1:0] ctrl_reg;
  logic [15:0] initLvl_reg, maxLvl_reg, rampTime1_reg, rampTime2_reg, utsTime_reg;
  logic [31:0] cur1_reg, cur2_reg, kick1_reg, kick2_reg;
  logic [IRQ_W-1:0] irqEn_reg, irqStat_reg, irqEvents;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic addrPhase;
  logic [15:0] tickCnt_reg;
  logic tick;
  logic selSync, selLive, useSet2_reg, selPrev_reg;
  sar_state_e state_reg, state_next;
  sar_mode_e mode;
  logic startCmd, kickEn, selAssigned;
  logic [15:0] rampCnt_reg, kickCnt_reg, utsCnt_reg, noCurCnt_reg;
  logic [15:0] rampInit, rampEnd, rampTime, kickLevel, kickTime, lerpLevel;
  logic active, utsExpire, noCurFault;

  assign startCmd = ctrl_reg[CTRL_START];
  assign mode = sar_mode_e'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign selAssigned = ctrl_reg[CTRL_SEL_ASSIGNED];
  assign kickEn = ctrl_reg[CTRL_KICK_EN];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  // Read decode; unmapped and write-only offsets read as zero
  function automatic logic [31:0] readMux(input logic [7:0] a);
    case (a)
      ADDR_CTRL: readMux = 32'(ctrl_reg);
      ADDR_STATUS: readMux = {14'h0000, faultCode, 2'h0, state_reg[5:1], useSet2_reg, selSync, up_to_speed};
      ADDR_IRQ_STAT: readMux = 32'(irqStat_reg);
      ADDR_IRQ_EN: readMux = 32'(irqEn_reg);
      ADDR_INIT_LVL: readMux = {16'h0000, initLvl_reg};
      ADDR_MAX_LVL: readMux = {16'h0000, maxLvl_reg};
      ADDR_RAMP_T1: readMux = {16'h0000, rampTime1_reg};
      ADDR_RAMP_T2: readMux = {16'h0000, rampTime2_reg};
      ADDR_CUR1: readMux = cur1_reg;
      ADDR_CUR2: readMux = cur2_reg;
      ADDR_KICK1: readMux = kick1_reg;
      ADDR_KICK2: readMux = kick2_reg;
      ADDR_UTS_T: readMux = {16'h0000, utsTime_reg};
      ADDR_SETPT: readMux = {14'h0000, setPointKind, setPoint};
      default: readMux = 32'h00000000;
    endcase
  endfunction

  // Only whole-word transfers are used, so hsize is not decoded
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase captured; read data registered for the data phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      wrAddr_reg <= {haddr[7:2], 2'h0};
      hrdata <= (addrPhase && !hwrite) ? readMux({haddr[7:2], 2'h0}) : 32'h00000000;
    end
  end

  // Parameter and control registers, written in the data phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= CTRL_RESET;
      initLvl_reg <= 16'h0000;
      maxLvl_reg <= 16'h0000;
      rampTime1_reg <= 16'h0000;
      rampTime2_reg <= 16'h0000;
      cur1_reg <= 32'h00000000;
      cur2_reg <= 32'h00000000;
      kick1_reg <= 32'h00000000;
      kick2_reg <= 32'h00000000;
      utsTime_reg <= 16'h0000;
      irqEn_reg <= '0;
    end else if (wrPend_reg) begin
      case (wrAddr_reg)
        ADDR_CTRL: ctrl_reg <= hwdata[CTRL_W-1:0];
        ADDR_IRQ_EN: irqEn_reg <= hwdata[IRQ_W-1:0];
        ADDR_INIT_LVL: initLvl_reg <= hwdata[15:0];
        ADDR_MAX_LVL: maxLvl_reg <= hwdata[15:0];
        ADDR_RAMP_T1: rampTime1_reg <= hwdata[15:0];
        ADDR_RAMP_T2: rampTime2_reg <= hwdata[15:0];
        ADDR_CUR1: cur1_reg <= hwdata;
        ADDR_CUR2: cur2_reg <= hwdata;
        ADDR_KICK1: kick1_reg <= hwdata;
        ADDR_KICK2: kick2_reg <= hwdata;
        ADDR_UTS_T: utsTime_reg <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write-one clear, event beats clear

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) irqStat_reg <= '0;
    else if (wrPend_reg && wrAddr_reg == ADDR_IRQ_CLR) irqStat_reg <= (irqStat_reg & ~hwdata[IRQ_W-1:0]) | irqEvents;
    else irqStat_reg <= irqStat_reg | irqEvents;
  end

  assign irq = |(irqStat_reg & irqEn_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Ramp time base

  // One tick per millisecond; all ramp, kick and timer counts are in ticks
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) tickCnt_reg <= 16'h0000;
    else if (tick) tickCnt_reg <= 16'h0000;
    else tickCnt_reg <= tickCnt_reg + 16'h0001;
  end

  assign tick = tickCnt_reg == 16'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Profile selection

  sar_sync3 u_selSync (
    .clock(clock),
    .rst_b(rst_b),
    .asyncIn(rampSelPin),
    .syncOut(selSync)
  );

  // Only an assigned input can select set 2
  assign selLive = selAssigned && selSync;

  // Selection frozen while up to speed; dropping start lets an unassigned input release set 2
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      useSet2_reg <= 1'b0;
      selPrev_reg <= 1'b0;
    end else begin
      selPrev_reg <= selLive;
      if (state_reg != ST_UTS || !startCmd) useSet2_reg <= selLive;
    end
  end

  // Parameter choice; the kick and the current ramp honour set 2, other ramps use set 1
  always_comb begin
    kickLevel = useSet2_reg ? kick2_reg[15:0] : kick1_reg[15:0];
    kickTime = useSet2_reg ? kick2_reg[31:16] : kick1_reg[31:16];
    rampTime = rampTime1_reg;
    rampInit = initLvl_reg;
    rampEnd = maxLvl_reg;
    case (mode)
      MODE_CURRENT: begin
        rampInit = useSet2_reg ? cur2_reg[15:0] : cur1_reg[15:0];
        rampEnd = useSet2_reg ? cur2_reg[31:16] : cur1_reg[31:16];
        rampTime = useSet2_reg ? rampTime2_reg : rampTime1_reg;
      end
      MODE_VOLTAGE: rampEnd = LEVEL_FULL;
      default: ;
    endcase
  end

  // Point on the ramp from ticks elapsed, shared by both profiles
  sar_lerp u_lerp (
    .clock(clock),
    .rst_b(rst_b),
    .startLvl(rampInit),
    .endLvl(rampEnd),
    .elapsed(rampCnt_reg),
    .duration(rampTime),
    .level(lerpLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start sequence

  assign active = state_reg == ST_KICK || state_reg == ST_RAMP || state_reg == ST_HOLD;
  assign utsExpire = active && utsCnt_reg >= utsTime_reg;
  assign noCurFault = (active || state_reg == ST_UTS) && noCurCnt_reg >= NOCUR_TICKS;

  // Next state; removal of the start command wins over all, and overload over the rest outside idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (startCmd) state_next = kickEn ? ST_KICK : ST_RAMP;
      ST_KICK: if (tick && kickCnt_reg + 16'h0001 >= kickTime) state_next = ST_RAMP;
      ST_RAMP: if (rampCnt_reg >= rampTime) state_next = ST_HOLD;
      ST_HOLD: ;
      ST_UTS: ;
      ST_TRIP: ;
      default: state_next = ST_IDLE;
    endcase
    if (active && (fullSpeed || utsExpire)) state_next = ST_UTS;
    if (state_reg != ST_IDLE && (overloadTrip || noCurFault)) state_next = ST_TRIP;
    if (!startCmd) state_next = ST_IDLE;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Kick and ramp progress; the ramp count is never reset by a set change
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      kickCnt_reg <= 16'h0000;
      rampCnt_reg <= 16'h0000;
    end else if (state_reg == ST_IDLE) begin
      kickCnt_reg <= 16'h0000;
      rampCnt_reg <= 16'h0000;
    end else begin
      if (state_reg == ST_KICK && tick) kickCnt_reg <= kickCnt_reg + 16'h0001;
      if (state_reg == ST_RAMP && tick && rampCnt_reg < rampTime) begin
        rampCnt_reg <= rampCnt_reg + 16'h0001;
      end
    end
  end

  // Up-to-speed timer runs from the start command, kick included
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) utsCnt_reg <= 16'h0000;
    else if (state_reg == ST_IDLE) utsCnt_reg <= 16'h0000;
    else if (active && tick) utsCnt_reg <= utsCnt_reg + 16'h0001;
  end

  // Ticks without motor current while the stage is firing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) noCurCnt_reg <= 16'h0000;
    else if (motorCurrentSeen || !(active || state_reg == ST_UTS)) noCurCnt_reg <= 16'h0000;
    else if (tick && noCurCnt_reg < NOCUR_TICKS) noCurCnt_reg <= noCurCnt_reg + 16'h0001;
  end

  // Fault code latched until the start command is removed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) faultCode <= 8'h00;
    else if (!startCmd) faultCode <= 8'h00;
    else if (noCurFault) faultCode <= FAULT_NO_CURRENT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set-point output

  // Voltage mode is pure open loop: no current term reaches this path
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      setPoint <= 16'h0000;
      setPointKind <= 2'h0;
      up_to_speed <= 1'b0;
    end else begin
      setPointKind <= mode;
      up_to_speed <= state_reg == ST_UTS;
      case (state_reg)
        ST_KICK: setPoint <= kickLevel;
        ST_RAMP: setPoint <= lerpLevel;
        ST_HOLD: setPoint <= lerpLevel;
        ST_UTS: if (mode == MODE_VOLTAGE) setPoint <= LEVEL_FULL;
        default: setPoint <= 16'h0000;
      endcase
    end
  end

  // Events for the interrupt status
  always_comb begin
    irqEvents = '0;
    irqEvents[IRQ_UTS] = state_next == ST_UTS && state_reg != ST_UTS;
    irqEvents[IRQ_HOLD] = state_next == ST_HOLD && state_reg == ST_RAMP;
    irqEvents[IRQ_TRIP] = state_next == ST_TRIP && state_reg != ST_TRIP;
    irqEvents[IRQ_NOCUR] = noCurFault && faultCode != FAULT_NO_CURRENT;
    irqEvents[IRQ_SELCHG] = active && selLive != selPrev_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence powerHolding;
    (state_reg == ST_HOLD && mode == MODE_POWER && $stable(maxLvl_reg))[*3];
  endsequence

  sequence rampBoth;
    state_reg == ST_RAMP ##1 state_reg == ST_RAMP;
  endsequence

  holdMaximum_a: assert property (powerHolding |-> setPoint == maxLvl_reg)
    else $error("power hold does not show the maximum level");

  voltFull_a: assert property (state_reg == ST_UTS && mode == MODE_VOLTAGE |=> setPoint == LEVEL_FULL)
    else $error("full voltage not commanded at up-to-speed");

  rampStart_a: assert property (
    (state_reg == ST_RAMP && rampCnt_reg == 16'h0000 && rampTime != 16'h0000 && $stable(rampInit))[*3]
    |-> setPoint == rampInit)
    else $error("ramp does not begin at the initial level");

  rampStep_a: assert property (rampBoth |->
    rampCnt_reg == $past(rampCnt_reg) + (($past(tick) && $past(rampCnt_reg) < $past(rampTime)) ? 16'h0001 : 16'h0000))
    else $error("ramp progress jumped or restarted");

  utsFrozen_a: assert property ($past(state_reg) == ST_UTS && state_reg == ST_UTS |-> $stable(useSet2_reg))
    else $error("selection changed after up-to-speed");

  noSelect_a: assert property ((!selAssigned)[*2] |-> !useSet2_reg)
    else $error("set 2 used without an assigned selection input");

  kickLevel_a: assert property (
    (state_reg == ST_KICK && $stable(kickLevel))[*2] |-> setPoint == kickLevel)
    else $error("kick level not applied");

  noCurrent_a: assert property (noCurFault && startCmd |=> faultCode == FAULT_NO_CURRENT)
    else $error("no-current fault code missing");

  utsOutput_a: assert property (state_reg == ST_UTS ##1 state_reg == ST_UTS |-> up_to_speed)
    else $error("up-to-speed not shown");
endmodule

// ---- rtl/sar_pkg.sv ----
package sar_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_INIT_LVL = 8'h14;
  localparam logic [7:0] ADDR_MAX_LVL = 8'h18;
  localparam logic [7:0] ADDR_RAMP_T1 = 8'h1c;
  localparam logic [7:0] ADDR_RAMP_T2 = 8'h20;
  localparam logic [7:0] ADDR_CUR1 = 8'h24;
  localparam logic [7:0] ADDR_CUR2 = 8'h28;
  localparam logic [7:0] ADDR_KICK1 = 8'h2c;
  localparam logic [7:0] ADDR_KICK2 = 8'h30;
  localparam logic [7:0] ADDR_UTS_T = 8'h34;
  localparam logic [7:0] ADDR_SETPT = 8'h38;
  // Control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_SEL_ASSIGNED = 3;
  localparam int CTRL_KICK_EN = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  // Interrupt bit positions
  localparam int IRQ_UTS = 0;
  localparam int IRQ_HOLD = 1;
  localparam int IRQ_TRIP = 2;
  localparam int IRQ_NOCUR = 3;
  localparam int IRQ_SELCHG = 4;
  localparam int IRQ_W = 5;
  // Levels are in tenths of a percent
  localparam logic [15:0] LEVEL_FULL = 16'h03e8;
  localparam logic [7:0] FAULT_NO_CURRENT = 8'h27;
  localparam logic [15:0] NOCUR_TICKS = 16'h0064;
  // Ramp tick of 1 ms at a 100 ns clock
  localparam int TICK_TIME_NS = 1000000;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  typedef enum logic [1:0] {
    MODE_CURRENT = 2'h0,
    MODE_TORQUE = 2'h1,
    MODE_POWER = 2'h2,
    MODE_VOLTAGE = 2'h3
  } sar_mode_e;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_KICK = 6'h02,
    ST_RAMP = 6'h04,
    ST_HOLD = 6'h08,
    ST_UTS = 6'h10,
    ST_TRIP = 6'h20
  } sar_state_e;
endpackage

// ---- rtl/sar_sync3.sv ----
module sar_sync3 (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Asynchronous level in, filtered level out
  input wire logic asyncIn,
  output logic syncOut
);
  import sar_pkg::*;

  logic q1_reg, q2_reg, q3_reg;

  // Three stages; a change counts only once stages two and three agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q1_reg <= 1'b0;
      q2_reg <= 1'b0;
      q3_reg <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      q1_reg <= asyncIn;
      q2_reg <= q1_reg;
      q3_reg <= q2_reg;
      if (q2_reg == q3_reg) syncOut <= q3_reg;
    end
  end

  syncAgree_a: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(syncOut) |-> $past(q2_reg) == $past(q3_reg))
    else $error("selection level changed without agreeing stages");
endmodule

// ---- rtl/sar_lerp.sv ----
module sar_lerp (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Ramp end points and progress
  input wire logic [15:0] startLvl,
  input wire logic [15:0] endLvl,
  input wire logic [15:0] elapsed,
  input wire logic [15:0] duration,
  // Interpolated level, one cycle later
  output logic [15:0] level
);
  import sar_pkg::*;

  logic signed [16:0] diff;
  logic signed [33:0] prod;
  logic signed [33:0] quo;
  logic [15:0] level_next;

  // Linear point from elapsed ticks, so a parameter swap keeps the progress
  always_comb begin
    diff = $signed({1'b0, endLvl}) - $signed({1'b0, startLvl});
    prod = 34'(diff * $signed({1'b0, elapsed}));
    quo = (duration == 16'h0000) ? 34'sh0 : prod / $signed({18'h0, duration});
    if (duration == 16'h0000 || elapsed >= duration) begin
      level_next = endLvl;
    end else begin
      level_next = 16'($signed({18'h0, startLvl}) + quo);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) level <= 16'h0000;
    else level <= level_next;
  end

  endReached_a: assert property (@(posedge clock) disable iff (!rst_b)
    (duration != 16'h0000 && elapsed == duration) |=> level == $past(endLvl))
    else $error("ramp did not land on its end value");
endmodule

// ---- tb/sar_motor_model.sv ----
module sar_motor_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Drive from the starter
  input wire logic [15:0] setPoint,
  // Scenario knobs
  input wire logic [31:0] loadNeed,
  input wire logic openPhase,
  input wire logic tripCmd,
  // Motor state back to the starter
  output logic fullSpeed,
  output logic overloadTrip,
  output logic motorCurrentSeen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] speedReg;
  ////////////////////////////////////////////////////////////////
  // Speed builds with applied drive; with no drive the speed is cleared to zero at once
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      speedReg <= 32'h0;
    end else if (setPoint == 16'h0000) begin
      speedReg <= 32'h0;
    end else begin
      speedReg <= speedReg + {16'h0, setPoint};
    end
  end
  // A heavy load needs more accumulated drive, so full speed may never come
  assign fullSpeed = (speedReg >= loadNeed) && (setPoint != 16'h0000);
  // Current flows with drive, unless a phase is open
  assign motorCurrentSeen = (setPoint != 16'h0000) && !openPhase;
  // Thermal trip is a registered level, as a relay contact would be
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overloadTrip <= 1'b0;
    end else begin
      overloadTrip <= tripCmd;
    end
  end
endmodule

// ---- tb/starter_accel_profile_ramp_test.sv ----
module starter_accel_profile_ramp_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sar_pkg::*;
  // Short tick keeps ramps of tens of ticks within a few thousand cycles
  localparam int TK = 8;
  logic clock, rst_b, hwrite, hreadyout, hresp, rampSelPin, fullSpeed, overloadTrip;
  logic motorCurrentSeen, up_to_speed, irq, openPhase, tripCmd;
  logic [31:0] haddr, hwdata, hrdata, loadNeed, rd;
  logic [1:0] htrans, setPointKind;
  logic [15:0] setPoint, ini, mx, k1, k2, sp;
  logic [7:0] faultCode;
  int fail_count, total_checks, cycleCount, seed, i;
  sar_accel_ramp #(.TICK_CYCLES(TK)) sar_accel_ramp_inst (.clock(clock), .rst_b(rst_b),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rampSelPin(rampSelPin), .fullSpeed(fullSpeed), .overloadTrip(overloadTrip),
    .motorCurrentSeen(motorCurrentSeen), .setPoint(setPoint), .setPointKind(setPointKind),
    .up_to_speed(up_to_speed), .faultCode(faultCode), .irq(irq));
  sar_motor_model sar_motor_model_inst (.clock(clock), .rst_b(rst_b), .setPoint(setPoint),
    .loadNeed(loadNeed), .openPhase(openPhase), .tripCmd(tripCmd), .fullSpeed(fullSpeed),
    .overloadTrip(overloadTrip), .motorCurrentSeen(motorCurrentSeen));
  ////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // One AHB single transfer; address held until hready, then data phase
  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(1'b1, a, d, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic waitUts(input int lim);
    for (int n = 0; n < lim && up_to_speed !== 1'b1; n++) @(posedge clock);
  endtask
  // Level taken from set 2 only when the select function is assigned and energized
  function automatic logic [15:0] pick(input logic asg, input logic pin, input logic [15:0] a,
    input logic [15:0] b);
    return (asg & pin) ? b : a;
  endfunction
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rampSelPin = 1'b0;
    loadNeed = 32'hffff_ffff;
    openPhase = 1'b0;
    tripCmd = 1'b0;
    fail_count = 0;
    total_checks = 0;
    cycleCount = 0;
    seed = 32'hbbd5;
    cyc(12);
    rst_b <= 1'b1;
    cyc(1);
    check({setPoint, faultCode, up_to_speed, irq, hreadyout, hresp}, 32'h2);
    // Register map: set storage, unmapped place and read-only status
    wr(ADDR_CUR2, 32'h01f4_0064);
    busXfer(1'b0, ADDR_CUR2, 32'h0, rd);
    check(rd, 32'h01f4_0064);
    busXfer(1'b0, 8'hfc, 32'h0, rd);
    check(rd, 32'h0);
    wr(ADDR_STATUS, 32'hffff_ffff);
    busXfer(1'b0, ADDR_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    wr(ADDR_CUR1, 32'h0320_0258);
    wr(ADDR_IRQ_EN, 32'h1f);
    // Power ramp under heavy load, set 2 selected but ramp time 1 must apply
    ini = 16'd100 + 16'($random(seed) & 255);
    mx = 16'd600 + 16'($random(seed) & 255);
    rampSelPin <= 1'b1;
    wr(ADDR_INIT_LVL, {16'h0, ini});
    wr(ADDR_MAX_LVL, {16'h0, mx});
    wr(ADDR_RAMP_T1, 32'd10);
    wr(ADDR_RAMP_T2, 32'd30);
    wr(ADDR_UTS_T, 32'd200);
    wr(ADDR_CTRL, 32'h0d);
    cyc(8 * TK);
    check(setPoint < mx && setPoint > ini, 1);
    cyc(4 * TK);
    check(setPoint, mx);
    check(setPointKind, 2'h2);
    busXfer(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
    check(rd[1] & irq, 1);
    cyc(10 * TK);
    check(setPoint, mx);
    tripCmd <= 1'b1;
    cyc(4);
    busXfer(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
    check(rd[2] && setPoint != mx, 1);
    tripCmd <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_IRQ_CLR, 32'h1f);
    // Light load: full speed ends the start below the power ceiling
    loadNeed <= 32'd2000;
    wr(ADDR_CTRL, 32'h0d);
    waitUts(10 * TK);
    check(up_to_speed, 1);
    check(setPoint < mx, 1);
    wr(ADDR_CTRL, 32'h0);
    loadNeed <= 32'hffff_ffff;
    // Voltage ramp cut short by the up-to-speed timer
    wr(ADDR_INIT_LVL, 32'd200);
    wr(ADDR_RAMP_T1, 32'd50);
    wr(ADDR_UTS_T, 32'd10);
    wr(ADDR_CTRL, 32'h07);
    cyc(5 * TK);
    check(setPoint >= 16'd200 && setPoint < LEVEL_FULL, 1);
    waitUts(20 * TK);
    cyc(2);
    check({up_to_speed, setPointKind, setPoint}, {1'b1, 2'h3, LEVEL_FULL});
    wr(ADDR_CTRL, 32'h0);
    // Voltage ramp with an open phase: no clamp, then the no-current fault
    openPhase <= 1'b1;
    wr(ADDR_RAMP_T1, 32'd20);
    wr(ADDR_UTS_T, 32'hffff);
    wr(ADDR_CTRL, 32'h07);
    cyc(24 * TK);
    check({faultCode, setPoint}, {8'h0, LEVEL_FULL});
    for (i = 0; i < 90 * TK && faultCode !== FAULT_NO_CURRENT; i++) cyc(1);
    check({faultCode, irq}, {FAULT_NO_CURRENT, 1'b1});
    wr(ADDR_IRQ_EN, 32'h0);
    cyc(1);
    check(irq, 0);
    wr(ADDR_IRQ_EN, 32'h1f);
    wr(ADDR_IRQ_CLR, 32'h1f);
    cyc(1);
    check(irq, 0);
    openPhase <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    // Current ramp with kick on set 2, switched to set 1 mid-ramp
    wr(ADDR_RAMP_T1, 32'd20);
    wr(ADDR_RAMP_T2, 32'd20);
    wr(ADDR_KICK1, 32'h0004_015e);
    wr(ADDR_KICK2, 32'h0004_03b6);
    rampSelPin <= 1'b1;
    cyc(6);
    wr(ADDR_CTRL, 32'h19);
    cyc(2 * TK);
    check(setPoint, 16'd950);
    cyc(12 * TK);
    check(setPoint >= 16'd260 && setPoint <= 16'd340, 1);
    rampSelPin <= 1'b0;
    cyc(1);
    check(setPoint <= 16'd340, 1);
    cyc(8);
    check(setPoint >= 16'd680 && setPoint <= 16'd730, 1);
    loadNeed <= 32'd1000;
    waitUts(100);
    cyc(2);
    sp = setPoint;
    rampSelPin <= 1'b1;
    cyc(10);
    busXfer(1'b0, ADDR_STATUS, 32'h0, rd);
    check({up_to_speed, rd[2:0], setPoint}, {1'b1, 3'h3, sp});
    busXfer(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
    check(rd, 32'h11);
    wr(ADDR_CTRL, 32'h0);
    loadNeed <= 32'hffff_ffff;
    // Kick and ramp start, assigned with pin high and low, and unassigned with pin low
    for (i = 0; i < 3; i++) begin
      k1 = 16'd20 + 16'($random(seed) & 255);
      k2 = k1 + 16'd600;
      wr(ADDR_KICK1, {16'd3, k1});
      wr(ADDR_KICK2, {16'd3, k2});
      rampSelPin <= (i == 0);
      cyc(6);
      wr(ADDR_CTRL, 32'h11 | ((i != 2) << 3));
      cyc(TK);
      check(setPoint, pick(i != 2, i == 0, k1, k2));
      sp = setPoint;
      for (int n = 0; n < 6 * TK && setPoint === sp; n++) cyc(1);
      cyc(1);
      check(setPoint, pick(i != 2, i == 0, 16'd600, 16'd100));
      wr(ADDR_CTRL, 32'h0);
    end
    give_verdict();
  end
endmodule
